// *** rtl/serial_master_pkg.sv ***
// Shared constants and types for the serial master supervisory block
package serial_master_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESP_TIMEOUT_NS = 20000;
	localparam int RESP_TIMEOUT_CYCLES = (RESP_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = $clog2(RESP_TIMEOUT_CYCLES + 1);
	localparam int RESET_CLEAR_CYCLES = 128;
	localparam int CLEAR_W = $clog2(RESET_CLEAR_CYCLES + 1);

	// ----------------------------------------------------------------
	// Network size and counts
	// ----------------------------------------------------------------
	localparam int NUM_DEV = 64;
	localparam int DEV_W = 6;
	localparam int BREAK_PERIOD = 16384;
	localparam int BREAK_W = $clog2(BREAK_PERIOD);
	localparam int RETRY_LIMIT = 3;
	localparam int CYC_FAIL_LIMIT = 3;

	// ----------------------------------------------------------------
	// Command words
	// ----------------------------------------------------------------
	localparam logic [15:0] CMD_SYS_ALL = 16'h1000;
	localparam logic [15:0] CMD_SYS_EXCL = 16'h1100;
	localparam logic [15:0] CMD_CYC_START = 16'h3000;
	localparam logic [15:0] CMD_SEND_BASE = 16'h4000;
	localparam logic [15:0] CMD_SEND_MASK = 16'hffc0;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int ENV_CYC_INT_MASK = 3;
	localparam int ENV_DATA_INT_MASK = 4;
	localparam int ENV_BREAK_EN = 8;
	localparam int ENV_READ_CLR_DIS = 9;
	localparam int ST_COMM_DONE = 0;
	localparam int ST_BREAK = 1;
	localparam int ST_CYC_ERR = 2;
	localparam int ST_DATA_ERR = 3;
	localparam int ST_RX_PEND = 10;
	localparam int ST_RESET_BUSY = 13;
	localparam int IST_NOT_RX = 7;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

	typedef enum logic [2:0] {
		FK_SYS = 3'h0,
		FK_CYC = 3'h1,
		FK_DATA = 3'h2,
		FK_RESEND = 3'h3,
		FK_BREAK = 3'h4
	} frame_kind_e;

	typedef enum logic [1:0] {
		RES_OK = 2'h0,
		RES_BAD = 2'h1,
		RES_NONE = 2'h2
	} result_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SEND = 2'h1,
		ST_WAIT = 2'h3,
		ST_EVAL = 2'h2
	} state_e;

endpackage

// *** rtl/rx_data_fifo.sv ***
// Receive data FIFO with flush, valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module rx_data_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rstN,
	input wire logic flush,
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wrPtr_reg;
	logic [PTR_W-1:0] rdPtr_reg;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic notEmpty_reg;
	logic notFull_reg;
	wire push = inValid && notFull_reg && !flush;
	wire pop = notEmpty_reg && outReady && !flush;

	function automatic logic [PTR_W-1:0] ptrInc(input logic [PTR_W-1:0] p);
		ptrInc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
	endfunction

	assign count_next = flush ? '0 : count_reg + CNT_W'(push) - CNT_W'(pop);
	assign inReady = notFull_reg;
	assign outValid = notEmpty_reg;
	assign outData = mem[rdPtr_reg];

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
			notEmpty_reg <= 1'b0;
			notFull_reg <= 1'b1;
		end else begin
			wrPtr_reg <= flush ? '0 : (push ? ptrInc(wrPtr_reg) : wrPtr_reg);
			rdPtr_reg <= flush ? '0 : (pop ? ptrInc(rdPtr_reg) : rdPtr_reg);
			count_reg <= count_next;
			// Flags kept as flops so the ports never see a decode glitch
			notEmpty_reg <= (count_next != '0);
			notFull_reg <= (count_next != CNT_W'(DEPTH));
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

endmodule // rx_data_fifo

`default_nettype wire

// *** rtl/serial_master_error_break_ctrl.sv ***
// Poll scheduler, retry, error, break and interrupt logic of the serial master
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Break request slot and break handling only while env bit 8 is one.
// - Break frame send request goes out every 16384 cyclic polling rounds.
// - Recognised break frame raises interrupt and sets status bit 1.
// - No cyclic retry; third consecutive failure sets device's cyclic error flag.
// - Cyclic error interrupts only while env bit 3 is zero; pending bit reported.
// - Host writes back read flags; ones clear flags and drop the request.
// - Data sent three times; then data error bit and device number stored.
// - Data error interrupts only while env bit 4 is zero.
// - Not-received flag one if no attempt answered, zero if answers were faulty.
// - With env bit 9 zero, status read drops interrupt, status kept.
// - Idle line past timeout means not received; retry with one cyclic round between.
// - After three failures flag error; quiet line sets not-received bit 7.
// - Faulty frame triggers up to two resend requests, each after a cyclic round.
// - Host holds reset ten clocks, then waits for reset-busy bit 13 low.
// - Commands 1000h, 3000h and 1100h start system, cyclic and excluded-device polls.
// - Send commands 4000h-403Fh pick device; done bit 0, data pending bit 10.
// - Writing a send command empties the receive FIFO.
// - No data communication while cyclic polling is stopped.
// - Cyclic polling skips devices whose in-use bit is zero.
// - System polling suspends cyclic polling, which resumes on completion.
module serial_master_error_break_ctrl
	import serial_master_pkg::*;
#(
	parameter int FIFO_DEPTH = 8,
	parameter int DATA_W = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [15:0] envConfig0,
	input wire logic cmdWrite,
	input wire logic [15:0] cmdWord,
	input wire logic cycStop,
	input wire logic statusRead,
	input wire logic cycErrClrWrite,
	input wire logic [NUM_DEV-1:0] cycErrClrData,
	input wire logic [NUM_DEV-1:0] deviceInUse,
	output logic frameReq,
	output logic [2:0] frameKind,
	output logic [DEV_W-1:0] frameDevice,
	input wire logic txDone,
	input wire logic rxValid,
	input wire logic rxOk,
	input wire logic lineIn,
	output logic devInfoWrite,
	output logic devInfoPresent,
	input wire logic rxDataValid,
	input wire logic [DATA_W-1:0] rxData,
	output logic rxDataReady,
	output logic hostDataValid,
	output logic [DATA_W-1:0] hostData,
	input wire logic hostDataReady,
	output logic [15:0] statusWord,
	output logic [15:0] intStatusWord,
	output logic [NUM_DEV-1:0] cycErrFlags,
	output logic intN
);

	// ----------------------------------------------------------------
	// Reset release and line synchroniser
	// ----------------------------------------------------------------
	logic rstSync1_reg;
	logic rstN;
	logic lineS1_reg;
	logic lineS2_reg;
	logic lineS3_reg;
	logic lineState_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstSync1_reg <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstSync1_reg <= 1'b1;
			rstN <= rstSync1_reg;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			lineS1_reg <= 1'b1;
			lineS2_reg <= 1'b1;
			lineS3_reg <= 1'b1;
			lineState_reg <= 1'b1;
		end else begin
			lineS1_reg <= lineIn;
			lineS2_reg <= lineS1_reg;
			lineS3_reg <= lineS2_reg;
			if (lineS2_reg == lineS3_reg) begin
				lineState_reg <= lineS3_reg;
			end
		end
	end

	wire lineEdge = (lineS2_reg == lineS3_reg) && (lineS3_reg != lineState_reg);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	state_e state_reg;
	state_e state_next;
	frame_kind_e kind_reg;
	result_e result_reg;
	logic frameReq_reg;
	logic [DEV_W-1:0] frameDev_reg;
	logic [TIMER_W-1:0] timer_reg;
	logic lineSeen_reg;
	logic resetBusy_reg;
	logic [CLEAR_W-1:0] clrCnt_reg;
	logic cycRun_reg;
	logic [DEV_W-1:0] cycDev_reg;
	logic [BREAK_W-1:0] roundCnt_reg;
	logic breakDue_reg;
	logic [1:0] failCnt [NUM_DEV];
	logic sysActive_reg;
	logic sysExclOnly_reg;
	logic sysHold_reg;
	logic [DEV_W-1:0] sysDev_reg;
	logic [1:0] sysTries_reg;
	logic dataPending_reg;
	logic dataArmed_reg;
	logic dataResend_reg;
	logic dataGotResp_reg;
	logic [DEV_W-1:0] dataDev_reg;
	logic [1:0] dataTries_reg;
	logic commDone_reg;
	logic breakFlag_reg;
	logic dataErr_reg;
	logic notRx_reg;
	logic [DEV_W-1:0] errDev_reg;
	logic [NUM_DEV-1:0] cycErr_reg;
	logic [NUM_DEV-1:0] cycErr_next;
	logic intMain_reg;
	logic intCyc_reg;
	logic intN_reg;
	logic [15:0] status_reg;
	logic [15:0] statusVal;
	logic devInfoWrite_reg;
	logic devInfoPresent_reg;

	function automatic logic isDataKind(input frame_kind_e k);
		isDataKind = (k == FK_DATA) || (k == FK_RESEND);
	endfunction

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	wire cmdOk = cmdWrite && !resetBusy_reg;
	wire isSysAll = cmdOk && (cmdWord == CMD_SYS_ALL);
	wire isSysExcl = cmdOk && (cmdWord == CMD_SYS_EXCL);
	wire isSysCmd = isSysAll || isSysExcl;
	wire isCycStart = cmdOk && (cmdWord == CMD_CYC_START);
	wire isSend = cmdOk && ((cmdWord & CMD_SEND_MASK) == CMD_SEND_BASE);
	wire sendAccept = isSend && cycRun_reg && !dataPending_reg;
	wire fifoFlush = isSend;

	// ----------------------------------------------------------------
	// Scheduler selection
	// ----------------------------------------------------------------
	wire idleFree = (state_reg == ST_IDLE) && !resetBusy_reg;
	wire breakElig = breakDue_reg && envConfig0[ENV_BREAK_EN];
	wire sysElig = sysActive_reg && !sysHold_reg;
	wire dataElig = dataPending_reg && dataArmed_reg && cycRun_reg;
	wire pickBreak = idleFree && breakElig;
	wire pickSys = idleFree && !breakElig && sysElig;
	wire pickData = idleFree && !breakElig && !sysElig && dataElig;
	wire pickCyc = idleFree && !breakElig && !sysElig && !dataElig && cycRun_reg;
	wire sysSkip = sysExclOnly_reg && deviceInUse[sysDev_reg];
	wire cycSkip = !deviceInUse[cycDev_reg];
	wire issue = pickBreak || (pickSys && !sysSkip) || pickData || (pickCyc && !cycSkip);
	wire frame_kind_e issueKind = pickBreak ? FK_BREAK :
		pickSys ? FK_SYS :
		pickData ? (dataResend_reg ? FK_RESEND : FK_DATA) : FK_CYC;
	wire [DEV_W-1:0] issueDev = pickSys ? sysDev_reg :
		pickData ? dataDev_reg :
		pickCyc ? cycDev_reg : '0;

	// ----------------------------------------------------------------
	// Result evaluation
	// ----------------------------------------------------------------
	wire evalNow = (state_reg == ST_EVAL);
	wire resOk = (result_reg == RES_OK);
	wire resNone = (result_reg == RES_NONE);
	wire evalCyc = evalNow && (kind_reg == FK_CYC);
	wire evalSys = evalNow && (kind_reg == FK_SYS);
	wire evalData = evalNow && isDataKind(kind_reg);
	wire evalBreak = evalNow && (kind_reg == FK_BREAK);
	wire sysLast = (sysTries_reg == 2'(RETRY_LIMIT - 1));
	wire dataLast = (dataTries_reg == 2'(RETRY_LIMIT - 1));
	wire cycAdv = (pickCyc && cycSkip) || evalCyc;
	wire cycWrap = cycAdv && (cycDev_reg == DEV_W'(NUM_DEV - 1));
	wire sysStep = (pickSys && sysSkip) || (evalSys && (resOk || sysLast));
	wire sysRetry = evalSys && !resOk && !sysLast;
	wire sysDoneAll = sysStep && (sysDev_reg == DEV_W'(NUM_DEV - 1));
	wire dataFinal = evalData && (resOk || dataLast);
	wire dataFail = evalData && !resOk && dataLast;
	wire dataRetry = evalData && !resOk && !dataLast;
	wire cycFailHit = evalCyc && !resOk && (failCnt[cycDev_reg] == 2'(CYC_FAIL_LIMIT - 1));
	wire breakSeen = evalBreak && !resNone;
	wire timeoutHit = (state_reg == ST_WAIT) && !rxValid &&
		(timer_reg == TIMER_W'(RESP_TIMEOUT_CYCLES - 1));
	wire roundEnd = cycWrap && (roundCnt_reg == BREAK_W'(BREAK_PERIOD - 1));

	// ----------------------------------------------------------------
	// Frame exchange state machine
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (issue) state_next = ST_SEND;
			end
			ST_SEND: begin
				if (txDone) state_next = ST_WAIT;
			end
			ST_WAIT: begin
				if (rxValid || timeoutHit) state_next = ST_EVAL;
			end
			ST_EVAL: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state_reg <= ST_IDLE;
			kind_reg <= FK_SYS;
			result_reg <= RES_NONE;
			frameReq_reg <= 1'b0;
			frameDev_reg <= '0;
			timer_reg <= '0;
			lineSeen_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			frameReq_reg <= issue;
			if (issue) begin
				kind_reg <= issueKind;
				frameDev_reg <= issueDev;
			end
			timer_reg <= (state_reg == ST_WAIT) ? timer_reg + TIMER_W'(1) : '0;
			lineSeen_reg <= (state_reg == ST_WAIT) && (lineSeen_reg || lineEdge);
			if (state_reg == ST_WAIT && rxValid) begin
				result_reg <= rxOk ? RES_OK : RES_BAD;
			end else if (timeoutHit) begin
				// A moving line without a decoded frame counts as a faulty answer
				result_reg <= (lineSeen_reg || lineEdge) ? RES_BAD : RES_NONE;
			end
		end
	end

	// ----------------------------------------------------------------
	// Reset clear, cyclic and break scheduling
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			clrCnt_reg <= '0;
			resetBusy_reg <= 1'b1;
			cycRun_reg <= 1'b0;
			cycDev_reg <= '0;
			roundCnt_reg <= '0;
			breakDue_reg <= 1'b0;
		end else begin
			if (resetBusy_reg) clrCnt_reg <= clrCnt_reg + CLEAR_W'(1);
			resetBusy_reg <= resetBusy_reg && (clrCnt_reg != CLEAR_W'(RESET_CLEAR_CYCLES - 1));
			cycRun_reg <= isCycStart || (cycRun_reg && !cycStop);
			if (cycAdv) cycDev_reg <= cycDev_reg + DEV_W'(1);
			if (cycWrap) roundCnt_reg <= roundCnt_reg + BREAK_W'(1);
			breakDue_reg <= envConfig0[ENV_BREAK_EN] &&
				(roundEnd || (breakDue_reg && !pickBreak));
		end
	end

	for (genvar d = 0; d < NUM_DEV; d++) begin : g_fail
		always_ff @(posedge clk or negedge rstN) begin
			if (!rstN) begin
				failCnt[d] <= 2'h0;
			end else if (evalCyc && cycDev_reg == DEV_W'(d)) begin
				failCnt[d] <= (resOk || cycFailHit) ? 2'h0 : failCnt[d] + 2'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// System polling
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			sysActive_reg <= 1'b0;
			sysExclOnly_reg <= 1'b0;
			sysHold_reg <= 1'b0;
			sysDev_reg <= '0;
			sysTries_reg <= '0;
			devInfoWrite_reg <= 1'b0;
			devInfoPresent_reg <= 1'b0;
		end else begin
			if (isSysCmd) begin
				sysActive_reg <= 1'b1;
				sysExclOnly_reg <= isSysExcl;
				sysDev_reg <= '0;
				sysTries_reg <= '0;
			end else begin
				if (sysDoneAll) sysActive_reg <= 1'b0;
				if (sysStep) sysDev_reg <= sysDev_reg + DEV_W'(1);
				sysTries_reg <= sysStep ? '0 : (sysRetry ? sysTries_reg + 2'h1 : sysTries_reg);
			end
			// While cyclic polling runs, one cyclic round sits between two attempts at the same device
			sysHold_reg <= cycRun_reg && !isSysCmd && (sysRetry || (sysHold_reg && !cycWrap));
			devInfoWrite_reg <= evalSys && (resOk || sysLast);
			if (evalSys) devInfoPresent_reg <= resOk;
		end
	end

	// ----------------------------------------------------------------
	// Data communication and status bits
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			dataPending_reg <= 1'b0;
			dataArmed_reg <= 1'b0;
			dataResend_reg <= 1'b0;
			dataGotResp_reg <= 1'b0;
			dataDev_reg <= '0;
			dataTries_reg <= '0;
			commDone_reg <= 1'b0;
			breakFlag_reg <= 1'b0;
			dataErr_reg <= 1'b0;
			notRx_reg <= 1'b0;
			errDev_reg <= '0;
		end else begin
			dataPending_reg <= sendAccept || (dataPending_reg && !dataFinal);
			// Armed only at a round boundary so cyclic I/O keeps its rhythm
			dataArmed_reg <= !sendAccept && !evalData && (cycWrap || dataArmed_reg);
			if (sendAccept) begin
				dataDev_reg <= cmdWord[DEV_W-1:0];
				dataTries_reg <= '0;
				dataResend_reg <= 1'b0;
				dataGotResp_reg <= 1'b0;
			end else if (evalData) begin
				if (dataRetry) dataTries_reg <= dataTries_reg + 2'h1;
				dataResend_reg <= (result_reg == RES_BAD);
				dataGotResp_reg <= dataGotResp_reg || !resNone;
			end
			commDone_reg <= (evalData && resOk) || (commDone_reg && !sendAccept);
			dataErr_reg <= dataFail || (dataErr_reg && !sendAccept);
			breakFlag_reg <= breakSeen || (breakFlag_reg && !isSysCmd);
			if (dataFail) begin
				errDev_reg <= dataDev_reg;
				notRx_reg <= !(dataGotResp_reg || !resNone);
			end
		end
	end

	// ----------------------------------------------------------------
	// Cyclic error flags and interrupt line
	// ----------------------------------------------------------------
	wire [NUM_DEV-1:0] cycNewMask = cycFailHit ? (NUM_DEV'(1) << cycDev_reg) : '0;
	wire [NUM_DEV-1:0] cycClrMask = cycErrClrWrite ? cycErrClrData : '0;
	wire readClr = statusRead && !envConfig0[ENV_READ_CLR_DIS];
	wire evtMain = breakSeen || (evalData && resOk) ||
		(dataFail && !envConfig0[ENV_DATA_INT_MASK]);
	wire evtCyc = cycFailHit && !envConfig0[ENV_CYC_INT_MASK];
	assign cycErr_next = (cycErr_reg & ~cycClrMask) | cycNewMask;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cycErr_reg <= '0;
			intMain_reg <= 1'b0;
			intCyc_reg <= 1'b0;
			intN_reg <= 1'b1;
		end else begin
			cycErr_reg <= cycErr_next;
			intMain_reg <= evtMain || (intMain_reg && !readClr);
			intCyc_reg <= evtCyc ||
				(intCyc_reg && !readClr && !(cycErrClrWrite && cycErr_next == '0));
			intN_reg <= !(intMain_reg || intCyc_reg);
		end
	end

	// ----------------------------------------------------------------
	// Status words
	// ----------------------------------------------------------------
	always_comb begin
		statusVal = STATUS_RESET;
		statusVal[ST_COMM_DONE] = commDone_reg;
		statusVal[ST_BREAK] = breakFlag_reg;
		statusVal[ST_CYC_ERR] = |cycErr_reg;
		statusVal[ST_DATA_ERR] = dataErr_reg;
		statusVal[ST_RX_PEND] = hostDataValid;
		statusVal[ST_RESET_BUSY] = resetBusy_reg;
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			status_reg <= STATUS_RESET;
		end else begin
			status_reg <= statusVal;
		end
	end

	// ----------------------------------------------------------------
	// Receive data path
	// ----------------------------------------------------------------
	rx_data_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk(clk),
		.rstN(rstN),
		.flush(fifoFlush),
		.inValid(rxDataValid),
		.inData(rxData),
		.inReady(rxDataReady),
		.outValid(hostDataValid),
		.outData(hostData),
		.outReady(hostDataReady)
	);

	assign frameReq = frameReq_reg;
	assign frameKind = kind_reg;
	assign frameDevice = frameDev_reg;
	assign devInfoWrite = devInfoWrite_reg;
	assign devInfoPresent = devInfoPresent_reg;
	assign statusWord = status_reg;
	assign intStatusWord = {8'h00, notRx_reg, 1'b0, errDev_reg};
	assign cycErrFlags = cycErr_reg;
	assign intN = intN_reg;

endmodule // serial_master_error_break_ctrl

`default_nettype wire

// *** dv/serial_master_error_break_ctrl_assertions.sv ***
// Concurrent checks on the supervisor's ports
`timescale 1ns/1ns
`default_nettype none
module serial_master_error_break_ctrl_checker
	import serial_master_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [15:0] envConfig0,
	input wire logic cmdWrite,
	input wire logic [15:0] cmdWord,
	input wire logic statusRead,
	input wire logic [NUM_DEV-1:0] deviceInUse,
	input wire logic frameReq,
	input wire logic [2:0] frameKind,
	input wire logic [DEV_W-1:0] frameDevice,
	input wire logic hostDataValid,
	input wire logic [15:0] statusWord,
	input wire logic [15:0] intStatusWord,
	input wire logic [NUM_DEV-1:0] cycErrFlags,
	input wire logic intN
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Issue decision sees the in-use bits one edge before the pulse
	logic [NUM_DEV-1:0] inUsePrev;
	always_ff @(posedge clk) inUsePrev <= deviceInUse;
	wire logic sendCmd = cmdWrite && ((cmdWord & CMD_SEND_MASK) == CMD_SEND_BASE);
	sequence s_readClr;
		statusRead && !envConfig0[ENV_READ_CLR_DIS] && !intN;
	endsequence
	sequence s_readKeep;
		statusRead && envConfig0[ENV_READ_CLR_DIS] && !intN;
	endsequence
	property p_flush;
		sendCmd && !statusWord[ST_RESET_BUSY] |=> !hostDataValid;
	endproperty
	property p_rd_clr;
		s_readClr |-> ##[1:2] intN;
	endproperty
	property p_rd_keep;
		s_readKeep |=> !intN [*2];
	endproperty
	property p_brk_set;
		$rose(statusWord[ST_BREAK]) |-> envConfig0[ENV_BREAK_EN];
	endproperty
	property p_brk_req;
		frameReq && frameKind == FK_BREAK |-> envConfig0[ENV_BREAK_EN] && frameDevice == 6'h00;
	endproperty
	property p_skip;
		frameReq && frameKind == FK_CYC |-> inUsePrev[frameDevice];
	endproperty
	property p_pend;
		|cycErrFlags |-> ##[0:2] statusWord[ST_CYC_ERR];
	endproperty
	property p_field;
		intStatusWord[15:8] == 8'h00 && !intStatusWord[6];
	endproperty
	a_flush: assert property (p_flush) else $error("receive data survived a send command");
	a_rd_clr: assert property (p_rd_clr) else $error("status read left interrupt low");
	a_rd_keep: assert property (p_rd_keep) else $error("status read cleared interrupt");
	a_brk_set: assert property (p_brk_set) else $error("break status with break off");
	a_brk_req: assert property (p_brk_req) else $error("bad break request frame");
	a_skip: assert property (p_skip) else $error("cyclic frame to unused device");
	a_pend: assert property (p_pend) else $error("cyclic error pending not shown");
	a_field: assert property (p_field) else $error("unused interrupt status bits set");
endmodule // serial_master_error_break_ctrl_checker
bind serial_master_error_break_ctrl serial_master_error_break_ctrl_checker checker_inst (
	.clk, .nrst, .envConfig0, .cmdWrite, .cmdWord, .statusRead, .deviceInUse, .frameReq,
	.frameKind, .frameDevice, .hostDataValid, .statusWord, .intStatusWord, .cycErrFlags, .intN
);
`default_nettype wire

// *** dv/frame_engine_model.sv ***
// Behavioural frame engine and local devices
`timescale 1ns/1ns
`default_nettype none
module frame_engine_model
	import serial_master_pkg::*;
(
	input wire logic clk,
	input wire logic frameReq,
	input wire logic [2:0] frameKind,
	input wire logic [DEV_W-1:0] frameDevice,
	input wire logic [NUM_DEV-1:0] deadMask,
	input wire logic [NUM_DEV-1:0] badMask,
	input wire logic breakWait,
	output logic txDone,
	output logic rxValid,
	output logic rxOk,
	output logic lineIn
);
	initial begin
		txDone = 1'b0;
		rxValid = 1'b0;
		rxOk = 1'b0;
		lineIn = 1'b1;
	end
	// Silent devices leave the line idle
	always @(posedge clk) begin
		if (frameReq) begin
			repeat (2) @(posedge clk);
			txDone <= 1'b1;
			@(posedge clk);
			txDone <= 1'b0;
			if (frameKind == FK_BREAK ? breakWait : !deadMask[frameDevice]) begin
				lineIn <= 1'b0;
				repeat (3) @(posedge clk);
				rxValid <= 1'b1;
				rxOk <= !badMask[frameDevice];
				@(posedge clk);
				rxValid <= 1'b0;
				rxOk <= !rxOk;
				lineIn <= 1'b1;
			end
		end
	end
endmodule // frame_engine_model
`default_nettype wire

// *** dv/serial_master_error_break_ctrl_tb_top.sv ***
// Self-checking bench for the supervisor
`timescale 1ns/1ns
`default_nettype none
module serial_master_error_break_ctrl_tb_top
	import serial_master_pkg::*;
;
	typedef struct {logic [15:0] env; logic [5:0] dev; logic [3:0] st; logic [7:0] ist; logic irqN;} row_s;
	row_s rows [5] = '{'{16'h0000, 6'h01, 4'h1, 8'h00, 1'b0}, '{16'h0000, 6'h05, 4'h8, 8'h85, 1'b0},
		'{16'h0000, 6'h06, 4'h8, 8'h06, 1'b0}, '{16'h0010, 6'h05, 4'h8, 8'h85, 1'b1},
		'{16'h0200, 6'h01, 4'h1, 8'h85, 1'b0}};
	logic clk = 0, nrst = 0, cmdWrite = 0, cycStop = 0, statusRead = 0, cycErrClrWrite = 0;
	logic rxDataValid = 0, hostDataReady = 0, breakWait = 0, hit;
	logic [15:0] envConfig0 = 16'h0000, cmdWord = 16'h0000, rxData = 16'h0000;
	logic [63:0] cycErrClrData = 64'h0, deviceInUse = 64'h3, deadMask = 64'h0, badMask = 64'h0;
	wire logic frameReq, txDone, rxValid, rxOk, lineIn, devInfoWrite, devInfoPresent;
	wire logic rxDataReady, hostDataValid, intN;
	wire logic [2:0] frameKind;
	wire logic [5:0] frameDevice;
	wire logic [15:0] hostData, statusWord, intStatusWord;
	wire logic [63:0] cycErrFlags;
	int bad_count = 0, checks_done = 0;
	always #5 clk = ~clk;
	serial_master_error_break_ctrl serial_master_error_break_ctrl_inst (.clk, .nrst, .envConfig0,
		.cmdWrite, .cmdWord, .cycStop, .statusRead, .cycErrClrWrite, .cycErrClrData, .deviceInUse,
		.frameReq, .frameKind, .frameDevice, .txDone, .rxValid, .rxOk, .lineIn, .devInfoWrite,
		.devInfoPresent, .rxDataValid, .rxData, .rxDataReady, .hostDataValid, .hostData,
		.hostDataReady, .statusWord, .intStatusWord, .cycErrFlags, .intN);
	frame_engine_model frame_engine_model_inst (.clk, .frameReq, .frameKind, .frameDevice,
		.deadMask, .badMask, .breakWait, .txDone, .rxValid, .rxOk, .lineIn);
	task check(input logic [64:0] seen, input logic [64:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("mismatches %0d checks %0d", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task cmd(input logic [15:0] w);
		@(negedge clk) {cmdWrite, cmdWord} = {1'b1, w};
		@(negedge clk) cmdWrite = 0;
	endtask
	task push(input logic [15:0] v);
		@(negedge clk) {rxDataValid, rxData} = {1'b1, v};
		@(negedge clk) rxDataValid = 0;
	endtask
	task wait_st(input logic [15:0] m, input logic v, input int n);
		for (int i = 0; i < n && (|(statusWord & m)) !== v; i++) @(negedge clk);
		if ((|(statusWord & m)) !== v) begin
			bad_count++;
			finish_test;
		end
	endtask
	// A required frame that never shows ends the run
	task wait_frame(input logic [2:0] k, input int n, input logic must);
		hit = 0;
		for (int i = 0; i < n && !hit; i++) begin
			@(negedge clk);
			hit = (frameReq === 1'b1) && (frameKind === k);
		end
		if (must) checks_done++;
		if (must && !hit) begin
			bad_count++;
			finish_test;
		end
	endtask
	initial begin
		repeat (10) @(negedge clk);
		check({intN, intStatusWord, statusWord}, {1'b1, 16'h0000, STATUS_RESET});
		nrst = 1;
		repeat (5) @(negedge clk);
		check(statusWord[ST_RESET_BUSY], 1'b1);
		wait_st(16'h2000, 1'b0, 400);
		cmd(CMD_CYC_START);
		wait_frame(FK_CYC, 100, 1'b1);
		cmd(CMD_SYS_ALL);
		wait_frame(FK_SYS, 100, 1'b1);
		wait_frame(FK_CYC, 3000, 1'b1);
		cmd(CMD_SYS_EXCL);
		wait_frame(FK_SYS, 100, 1'b1);
		check(deviceInUse[frameDevice], 1'b0);
		wait_frame(FK_CYC, 3000, 1'b1);
		check(devInfoPresent, 1'b1);
		for (int i = 0; i < 9; i++) push(16'h00a0 + 16'(i));
		check(rxDataReady, 1'b0);
		for (int i = 0; i < 8; i++) begin
			check({hostDataValid, hostData}, {1'b1, 16'h00a0 + 16'(i)});
			@(negedge clk) hostDataReady = 1;
			@(negedge clk) hostDataReady = 0;
		end
		repeat (2) @(negedge clk);
		check(hostDataValid, 1'b0);
		{deadMask, badMask} = {64'h20, 64'h40};
		foreach (rows[i]) begin
			envConfig0 = rows[i].env;
			push(16'h0055);
			repeat (3) @(negedge clk);
			check(statusWord[ST_RX_PEND], 1'b1);
			cmd(CMD_SEND_BASE | {10'h000, rows[i].dev});
			check(hostDataValid, 1'b0);
			repeat (3) @(negedge clk);
			wait_st(16'h0009, 1'b1, 20000);
			repeat (3) @(negedge clk);
			check(statusWord[3:0], rows[i].st);
			check(intStatusWord[7:0], rows[i].ist);
			check(intN, rows[i].irqN);
			@(negedge clk) statusRead = 1;
			@(negedge clk) statusRead = 0;
			repeat (3) @(negedge clk);
			check(intN, rows[i].env[9] ? rows[i].irqN : 1'b1);
		end
		envConfig0 = 16'h0000;
		@(negedge clk) statusRead = 1;
		@(negedge clk) {statusRead, deviceInUse[2], deadMask[2]} = 3'b011;
		wait_st(16'h0004, 1'b1, 20000);
		check(cycErrFlags, 64'h4);
		repeat (3) @(negedge clk);
		check({statusWord[ST_CYC_ERR], intN}, 2'b10);
		@(negedge clk) {cycErrClrWrite, cycErrClrData} = {1'b1, 64'h4};
		@(negedge clk) {cycErrClrWrite, deviceInUse[2]} = 2'b00;
		repeat (3) @(negedge clk);
		check({cycErrFlags, intN}, 65'h1);
		@(negedge clk) cycStop = 1;
		@(negedge clk) cycStop = 0;
		cmd(CMD_SEND_BASE | 16'h0001);
		wait_frame(FK_DATA, 3000, 1'b0);
		check(hit, 1'b0);
		finish_test;
	end
endmodule // serial_master_error_break_ctrl_tb_top
`default_nettype wire
